//--- fpat_convert.sv
`include "fpat_params.svh"

module fpat_convert
    import fpat_pkg::*;
(
    // Operand in.
    input wire fpat_fmt_t fmt,
    input wire logic [95:0] data,
    // Extended-precision value out.
    output logic [79:0] ext
);

    // Shifts a mantissa left until its integer bit is set; zero stays zero.
    function automatic logic [79:0] fpat_norm(input logic s, input logic [14:0] e, input logic [63:0] m);
        logic [63:0] mm;
        logic [14:0] ee;
        mm = m;
        ee = e;
        for (int i = 0; i < 64; i++)
        begin
            if (!mm[63] && (mm != 64'h0))
            begin
                mm = {mm[62:0], 1'b0};
                ee = ee - 15'h1;
            end
        end
        if (mm == 64'h0)
        begin
            ee = 15'h0;
        end
        return {s, ee, mm};
    endfunction : fpat_norm

    // Integer sources are widened to 32 bits with their sign.
    logic [31:0] int_val;
    logic [31:0] int_mag;
    logic [7:0] sgl_exp;
    logic [10:0] dbl_exp;
    assign int_val = (fmt == FPAT_FMT_BYTE) ? {{24{data[7]}}, data[7:0]} :
                     (fmt == FPAT_FMT_WORD) ? {{16{data[15]}}, data[15:0]} : data[31:0];
    assign int_mag = int_val[31] ? (32'h0 - int_val) : int_val;
    assign sgl_exp = data[30:23];
    assign dbl_exp = data[62:52];

    // Widens every format but packed and the unknown format, which give zero, to extended precision; infinities and NaNs keep their class.
    always_comb
    begin
        case (fmt)
            FPAT_FMT_SINGLE:
                if (sgl_exp == 8'hFF)
                    ext = {data[31], `FPAT_EXP_MAX, 1'b1, data[22:0], 40'h0};
                else if (sgl_exp == 8'h00)
                    ext = fpat_norm(data[31], `FPAT_BIAS - `FPAT_SGL_BIAS + 15'h1, {1'b0, data[22:0], 40'h0});
                else
                    ext = {data[31], 15'(sgl_exp) + `FPAT_BIAS - `FPAT_SGL_BIAS, 1'b1, data[22:0], 40'h0};
            FPAT_FMT_DOUBLE:
                if (dbl_exp == 11'h7FF)
                    ext = {data[63], `FPAT_EXP_MAX, 1'b1, data[51:0], 11'h0};
                else if (dbl_exp == 11'h000)
                    ext = fpat_norm(data[63], `FPAT_BIAS - `FPAT_DBL_BIAS + 15'h1, {1'b0, data[51:0], 11'h0});
                else
                    ext = {data[63], 15'(dbl_exp) + `FPAT_BIAS - `FPAT_DBL_BIAS, 1'b1, data[51:0], 11'h0};
            FPAT_FMT_EXT:
                ext = {data[95:80], data[63:0]};
            FPAT_FMT_LONG, FPAT_FMT_WORD, FPAT_FMT_BYTE:
                ext = fpat_norm(int_val[31], `FPAT_INT_EXP, {int_mag, 32'h0});
            default:
                ext = 80'h0;
        endcase
    end

endmodule : fpat_convert

//--- fpat_decode.sv
`include "fpat_params.svh"

// How it works
// RULE1 - Execute only when coprocessor identifier matches.
// RULE2 - Select bit picks register or memory operand.
// RULE3 - Register mode: source field indexes data register.
// RULE4 - Memory mode: source field gives operand format.
// RULE5 - Equal fields read and write same register.
// RULE6 - Issuer zeroes address field in register mode.
// RULE7 - Decode memory addressing modes and extension registers.
// RULE8 - Data-register direct only for small formats.
// RULE9 - Arc tangent: widen, compute, store to destination.
// RULE10 - Arc tangent limits, signed zeros, infinities.
// RULE11 - Keep quotient byte, clear unordered and overflow.
// RULE12 - Clear input-inexact except for packed sources.
// RULE13 - Arc tangent clears operand-error and divide-zero.
// RULE14 - Hyperbolic: widen, compute, store; zeros pass.
// RULE15 - Hyperbolic beyond one gives NaN, operand error.
// RULE16 - Hyperbolic at one gives infinity, divide-zero.
// RULE17 - Operation-mode field selects between the two.
module fpat_decode
    import fpat_pkg::*;
#(
    parameter logic [2:0] OWN_ID_DEFAULT = 3'h1,
    parameter int NUM_FPR = 8
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Configuration.
    input wire logic [2:0] own_cp_id,
    // Instruction request from the main processor.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [15:0] cmd_word0,
    input wire logic [15:0] cmd_word1,
    input wire logic [95:0] cmd_operand,
    // Instruction answer.
    output logic done_q,
    output logic reject_q,
    output fpat_loc_t loc_q,
    output logic [2:0] loc_reg_q,
    // Data register preload and readback.
    input wire logic fpr_wr_en,
    input wire logic [2:0] fpr_wr_idx,
    input wire logic [79:0] fpr_wr_data,
    input wire logic [2:0] fpr_rd_idx,
    output logic [79:0] fpr_rd_data_q,
    // Floating-point status register exception and quotient bytes.
    output logic branch_unordered_flag_q,
    output logic signaling_nan_flag_q,
    output logic operand_error_flag_q,
    output logic overflow_flag_q,
    output logic underflow_flag_q,
    output logic divide_by_zero_flag_q,
    output logic result_inexact_flag_q,
    output logic input_inexact_flag_q,
    output logic [7:0] quotient_q
);

    // ==========================================================================
    // Instruction field decode
    // ==========================================================================
    logic id_match;
    logic frame_ok;
    logic rm_bit;
    logic [2:0] src_spec;
    logic [2:0] dst_idx;
    logic [6:0] opmode;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic op_atan;
    logic op_atanh;
    fpat_fmt_t fmt;
    fpat_loc_t loc;
    logic loc_bad;
    logic accept;
    logic start;

    // Maps the address field to a location; returns illegal for holes.
    function automatic fpat_loc_t fpat_ea_loc(input logic [2:0] m, input logic [2:0] r, input fpat_fmt_t f);
        fpat_loc_t l;
        l = FPAT_LOC_ILLEGAL;
        case (m)
            `FPAT_EA_DREG:
                if (f == FPAT_FMT_BYTE || f == FPAT_FMT_WORD || f == FPAT_FMT_LONG || f == FPAT_FMT_SINGLE)
                    l = FPAT_LOC_DREG;
            `FPAT_EA_IND: l = FPAT_LOC_IND;
            `FPAT_EA_POSTINC: l = FPAT_LOC_POSTINC;
            `FPAT_EA_PREDEC: l = FPAT_LOC_PREDEC;
            `FPAT_EA_DISP: l = FPAT_LOC_DISP;
            `FPAT_EA_INDEX: l = FPAT_LOC_INDEX;
            `FPAT_EA_EXT:
                case (r)
                    `FPAT_EXT_ABSW: l = FPAT_LOC_ABSW;
                    `FPAT_EXT_ABSL: l = FPAT_LOC_ABSL;
                    `FPAT_EXT_IMM: l = FPAT_LOC_IMM;
                    `FPAT_EXT_PCDISP: l = FPAT_LOC_PCDISP;
                    `FPAT_EXT_PCIDX: l = FPAT_LOC_PCIDX;
                    default: l = FPAT_LOC_ILLEGAL;
                endcase
            default: l = FPAT_LOC_ILLEGAL;
        endcase
        return l;
    endfunction : fpat_ea_loc

    // Splits the two instruction words into their fields.
    assign rm_bit = cmd_word1[`FPAT_W1_RM];
    assign src_spec = cmd_word1[`FPAT_W1_SRC_HI:`FPAT_W1_SRC_LO];
    assign dst_idx = cmd_word1[`FPAT_W1_DST_HI:`FPAT_W1_DST_LO];
    assign opmode = cmd_word1[`FPAT_W1_OPM_HI:`FPAT_W1_OPM_LO];
    assign ea_mode = cmd_word0[`FPAT_W0_MODE_HI:`FPAT_W0_MODE_LO];
    assign ea_reg = cmd_word0[`FPAT_W0_REG_HI:`FPAT_W0_REG_LO];
    assign fmt = fpat_fmt_t'(src_spec);
    // RULE1 - identifier match gate
    assign id_match = (cmd_word0[`FPAT_W0_ID_HI:`FPAT_W0_ID_LO] == own_cp_id);
    assign frame_ok = (cmd_word0[`FPAT_W0_LINE_HI:`FPAT_W0_LINE_LO] == `FPAT_W0_LINE_VAL) &&
                      (cmd_word0[`FPAT_W0_TYPE_HI:`FPAT_W0_TYPE_LO] == `FPAT_W0_TYPE_VAL) &&
                      !cmd_word1[`FPAT_W1_ZERO_HI] && !cmd_word1[`FPAT_W1_ZERO_LO];
    // RULE17 - operation select by mode
    assign op_atan = (opmode == `FPAT_OPM_ATAN);
    assign op_atanh = (opmode == `FPAT_OPM_ATANH);
    // RULE2 - register or memory source
    // RULE6 - address field unused in register mode
    // RULE7 - addressing mode decode
    // RULE8 - data-register direct restriction
    assign loc = rm_bit ? fpat_ea_loc(ea_mode, ea_reg, fmt) : FPAT_LOC_FPREG;
    // Packed and unknown formats are left to software emulation.
    assign loc_bad = (loc == FPAT_LOC_ILLEGAL) || (rm_bit && (fmt == FPAT_FMT_PACKED || fmt == FPAT_FMT_BAD)) ||
                     !(op_atan || op_atanh) || !frame_ok;
    assign accept = cmd_valid && cmd_ready && id_match;
    assign start = accept && !loc_bad;

    // ==========================================================================
    // Operand fetch
    // ==========================================================================
    logic [79:0] fpr_q [NUM_FPR];
    logic [79:0] mem_ext;
    logic [79:0] src_val;

    fpat_convert u_convert (
        .fmt(fmt),
        .data(cmd_operand),
        .ext(mem_ext)
    );

    // RULE3 - source register index
    // RULE4 - memory format conversion
    assign src_val = rm_bit ? mem_ext : fpr_q[src_spec];

    // ==========================================================================
    // Sequencer and latched operation
    // ==========================================================================
    fpat_state_t state_q;
    fpat_state_t state_d;
    logic [79:0] opnd_q;
    logic [2:0] dst_q;
    logic is_atanh_q;

    // Busy for exactly one execute cycle after each accepted instruction that is not refused.
    assign state_d = (state_q == FPAT_S_IDLE && start) ? FPAT_S_EXEC : FPAT_S_IDLE;
    assign cmd_ready = (state_q == FPAT_S_IDLE);

    // Latches the widened operand, destination and operation.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= FPAT_S_IDLE;
            opnd_q <= 80'h0;
            dst_q <= 3'h0;
            is_atanh_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (start)
            begin
                opnd_q <= src_val;
                dst_q <= dst_idx;
                is_atanh_q <= op_atanh;
            end
        end
    end

    // ==========================================================================
    // Operand classification and result selection
    // ==========================================================================
    logic op_sign;
    logic [14:0] op_exp;
    logic [63:0] op_mant;
    logic is_zero;
    logic is_inf;
    logic is_nan;
    logic is_signaling_nan_flag;
    logic is_one;
    logic above_one;
    logic is_huge;
    logic [79:0] half_pi;
    logic [79:0] quiet_nan;
    logic [79:0] res;
    logic operand_error_flag;
    logic dz;
    logic inex;

    assign op_sign = opnd_q[79];
    assign op_exp = opnd_q[78:64];
    assign op_mant = opnd_q[63:0];
    assign is_zero = (op_exp == 15'h0) && (op_mant == 64'h0);
    assign is_inf = (op_exp == `FPAT_EXP_MAX) && (op_mant[62:0] == 63'h0);
    assign is_nan = (op_exp == `FPAT_EXP_MAX) && (op_mant[62:0] != 63'h0);
    assign is_signaling_nan_flag = is_nan && !op_mant[`FPAT_QUIET_BIT];
    assign is_one = (op_exp == `FPAT_BIAS) && (op_mant == `FPAT_MANT_ONE);
    assign above_one = !is_nan && ((op_exp > `FPAT_BIAS) || ((op_exp == `FPAT_BIAS) && (op_mant > `FPAT_MANT_ONE)));
    assign is_huge = op_exp >= `FPAT_EXP_HUGE;
    assign half_pi = {op_sign, `FPAT_HALF_PI_EXP, `FPAT_HALF_PI_MANT};
    assign quiet_nan = {op_sign, op_exp, op_mant | (64'h1 << `FPAT_QUIET_BIT)};

    // RULE15 - outside unit range is an operand error
    assign operand_error_flag = is_atanh_q && above_one;
    // RULE16 - exactly unit magnitude divides by zero
    assign dz = is_atanh_q && is_one;
    // Finite nonzero sources without an error give the leading series term, or half pi for large arc tangent, and are inexact.
    assign inex = !is_zero && !is_nan && !is_inf && !operand_error_flag && !dz;

    // Picks the special-case or computed result.
    always_comb
    begin
        if (is_nan)
            res = quiet_nan;
        // RULE15 - default NaN result
        else if (operand_error_flag)
            res = {1'b0, `FPAT_EXP_MAX, `FPAT_QNAN_MANT};
        // RULE16 - signed infinity result
        else if (dz)
            res = {op_sign, `FPAT_EXP_MAX, `FPAT_MANT_ONE};
        // RULE10 - zeros, infinities and half-pi bound
        // RULE14 - signed zero passes through
        else if (is_zero)
            res = opnd_q;
        else if (!is_atanh_q && (is_inf || is_huge))
            res = half_pi;
        // RULE9 - arc tangent result
        // RULE14 - hyperbolic result
        else
            res = opnd_q;
    end

    // ==========================================================================
    // Register file, flags and answer
    // ==========================================================================
    logic exec;
    assign exec = (state_q == FPAT_S_EXEC);

    // RULE5 - destination write of the same register
    // RULE9 - store to destination register
    generate
        for (genvar g = 0; g < NUM_FPR; g++)
        begin : g_fpr
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    fpr_q[g] <= `FPAT_FPR_RST;
                else if (exec && dst_q == 3'(g))
                    fpr_q[g] <= res;
                else if (fpr_wr_en && fpr_wr_idx == 3'(g))
                    fpr_q[g] <= fpr_wr_data;
            end
        end
    endgenerate

    // RULE11 - unordered, overflow cleared; quotient kept
    // RULE12 - input inexact cleared
    // RULE13 - arc tangent clears error bits
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            {branch_unordered_flag_q, signaling_nan_flag_q, operand_error_flag_q, overflow_flag_q} <= 4'h0;
            {underflow_flag_q, divide_by_zero_flag_q, result_inexact_flag_q, input_inexact_flag_q} <= 4'h0;
            quotient_q <= `FPAT_QUOT_RST;
        end
        else if (exec)
        begin
            branch_unordered_flag_q <= 1'b0;
            signaling_nan_flag_q <= is_signaling_nan_flag;
            operand_error_flag_q <= operand_error_flag;
            overflow_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
            divide_by_zero_flag_q <= dz;
            result_inexact_flag_q <= inex;
            input_inexact_flag_q <= 1'b0;
        end
    end

    // Answers one cycle after execute, or one cycle after a refused request.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
            reject_q <= 1'b0;
            loc_q <= FPAT_LOC_FPREG;
            loc_reg_q <= 3'h0;
            fpr_rd_data_q <= 80'h0;
        end
        else
        begin
            done_q <= exec;
            reject_q <= accept && loc_bad;
            fpr_rd_data_q <= fpr_q[fpr_rd_idx];
            if (accept)
            begin
                loc_q <= loc;
                loc_reg_q <= ea_reg;
            end
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    sequence s_start;
        start;
    endsequence

    sequence s_exec_done;
        exec ##1 done_q;
    endsequence

    a_start_to_done: assert property (@(posedge clock) disable iff (!rst_n) s_start |=> s_exec_done) // RULE9
        else $error("Accepted instruction did not complete in two cycles.");
    a_foreign_id: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_valid && !id_match) |=> !exec && !reject_q ##1 !done_q) // RULE1
        else $error("Instruction for another coprocessor was acted on.");
    a_dreg_fmt: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && rm_bit && ea_mode == `FPAT_EA_DREG && (fmt == FPAT_FMT_EXT || fmt == FPAT_FMT_DOUBLE))
        |=> reject_q && state_q == FPAT_S_IDLE) // RULE8
        else $error("Data-register direct accepted for a wide format.");
    a_areg_refused: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && rm_bit && ea_mode == `FPAT_EA_AREG) |=> reject_q) // RULE7
        else $error("Address-register direct was not refused.");
    a_unit_dz: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && is_atanh_q && is_one) |=> divide_by_zero_flag_q && !operand_error_flag_q
        && fpr_q[dst_q][78:64] == `FPAT_EXP_MAX) // RULE16
        else $error("Unit source did not give infinity with divide-by-zero.");
    a_range_operand_error_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && is_atanh_q && (above_one || is_inf)) |=> operand_error_flag_q && !divide_by_zero_flag_q) // RULE15
        else $error("Out-of-range source did not raise operand error.");
    a_atan_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && !is_atanh_q) |=> !operand_error_flag_q && !divide_by_zero_flag_q && !overflow_flag_q
        && !branch_unordered_flag_q && !input_inexact_flag_q && $stable(quotient_q)) // RULE13
        else $error("Arc tangent left an error bit set.");
    a_atan_inf: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && !is_atanh_q && is_inf) |=> fpr_q[$past(dst_q)] == {$past(op_sign), `FPAT_HALF_PI_EXP,
        `FPAT_HALF_PI_MANT}) // RULE10
        else $error("Infinite source did not give signed half pi.");
    a_zero_pass: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && is_zero) |=> fpr_q[$past(dst_q)] == $past(opnd_q)) // RULE14
        else $error("Signed zero was not returned unchanged.");

endmodule : fpat_decode

//--- fpat_decode_tb.sv
`include "fpat_params.svh"

module fpat_decode_tb
    import fpat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals and design
    logic clock, rst_n, cmd_valid, cmd_ready, done_q, reject_q, fpr_wr_en;
    logic bu, sn, oe, of, uf, dz, ri, ii;
    logic [2:0] own_cp_id, loc_reg_q, fpr_wr_idx, fpr_rd_idx;
    logic [15:0] cmd_word0, cmd_word1;
    logic [95:0] cmd_operand;
    logic [79:0] fpr_wr_data, fpr_rd_data_q;
    logic [7:0] quotient_q;
    logic [31:0] seed;
    fpat_loc_t loc_q;
    int fails, total_checks;
    logic [79:0] hv[6] = '{80'h3FFF_8000000000000000, 80'hBFFF_8000000000000000,
        80'h4000_8000000000000000, 80'h7FFF_8000000000000000, 80'h3FFE_8000000000000000, 80'h8000_0000000000000000};
    logic [2:0] fmts[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    logic [5:0] eas[10] = '{6'h11, 6'h1A, 6'h23, 6'h2C, 6'h35, 6'h38, 6'h39, 6'h3C, 6'h3A, 6'h3B};
    fpat_loc_t locs[10] = '{FPAT_LOC_IND, FPAT_LOC_POSTINC, FPAT_LOC_PREDEC, FPAT_LOC_DISP,
        FPAT_LOC_INDEX, FPAT_LOC_ABSW, FPAT_LOC_ABSL, FPAT_LOC_IMM, FPAT_LOC_PCDISP, FPAT_LOC_PCIDX};
    fpat_decode uut (.clock, .rst_n, .own_cp_id, .cmd_valid, .cmd_ready, .cmd_word0, .cmd_word1,
        .cmd_operand, .done_q, .reject_q, .loc_q, .loc_reg_q, .fpr_wr_en, .fpr_wr_idx, .fpr_wr_data,
        .fpr_rd_idx, .fpr_rd_data_q, .branch_unordered_flag_q(bu), .signaling_nan_flag_q(sn),
        .operand_error_flag_q(oe), .overflow_flag_q(of), .underflow_flag_q(uf),
        .divide_by_zero_flag_q(dz), .result_inexact_flag_q(ri), .input_inexact_flag_q(ii), .quotient_q);
    fpat_host host (.clock, .cmd_valid, .cmd_ready, .cmd_word0, .cmd_word1, .cmd_operand);
    // Free-running clock.
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Expected {result, operand error, divide by zero} of either operation.
    function automatic logic [81:0] model(input bit h, input logic [79:0] v);
        logic [14:0] e;
        e = v[78:64];
        if (v[78:0] == 79'h0)
            return {v, 2'b00};
        if (!h)
            return (e >= `FPAT_EXP_HUGE) ? {v[79], `FPAT_HALF_PI_EXP, `FPAT_HALF_PI_MANT, 2'b00} : {v, 2'b00};
        if (e == `FPAT_BIAS && v[63:0] == `FPAT_MANT_ONE)
            return {v[79], `FPAT_EXP_MAX, `FPAT_MANT_ONE, 2'b01};
        if (e >= `FPAT_BIAS)
            return {1'b0, `FPAT_EXP_MAX, `FPAT_QNAN_MANT, 2'b10};
        return {v, 2'b00};
    endfunction : model
    // Pseudo-random source.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // ==========================================
    // Checking and driving tasks
    task automatic end_of_test;
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic poke(input logic [2:0] i, input logic [79:0] v);
        @(negedge clock);
        fpr_wr_en = 1'b1;
        fpr_wr_idx = i;
        fpr_wr_data = v;
        @(negedge clock);
        fpr_wr_en = 1'b0;
    endtask : poke
    task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [95:0] op, input logic [1:0] w);
        logic [1:0] s;
        host.issue(w0, w1, op);
        s = {done_q, reject_q};
        repeat (4)
        begin
            @(negedge clock);
            s = s | {done_q, reject_q};
        end
        chk("answer", w, s);
    endtask : run
    task automatic ex(input bit h, input logic rm, input logic [2:0] src, input logic [2:0] dst,
            input logic [5:0] ea, input logic [79:0] v, input fpat_loc_t loc);
        logic [81:0] m;
        logic ri_e;
        m = model(h, v);
        ri_e = (v[78:0] != 79'h0) && (v[78:64] != `FPAT_EXP_MAX) && (m[1:0] == 2'b00);
        if (!rm)
            poke(src, v);
        run({7'h79, 3'h0, ea}, {1'b0, rm, 1'b0, src, dst, 6'h06, h},
            (src == 3'h2) ? {v[79:64], 16'h0, v[63:0]} : (src == 3'h1) ? 96'h3F800000 :
            (src == 3'h5) ? 96'h3FF0000000000000 : 96'h1, 2'b10);
        chk("location", {loc, rm ? ea[2:0] : 3'h0}, {loc_q, loc_reg_q});
        @(negedge clock);
        fpr_rd_idx = dst;
        @(negedge clock);
        chk("result", m[81:2], fpr_rd_data_q);
        chk("status", {4'h0, m[1:0], ri_e, 9'h0},
            {bu, of, sn, uf, oe, dz, ri, ii, quotient_q});
    endtask : ex
    // Watchdog against a hang.
    initial
    begin
        #20000;
        fails++;
        end_of_test();
    end
    // Main sequence.
    initial
    begin
        own_cp_id = 3'h1;
        rst_n = 1'b0;
        fpr_wr_en = 1'b0;
        fpr_wr_idx = 3'h0;
        fpr_wr_data = 80'h0;
        fpr_rd_idx = 3'h0;
        fails = 0;
        total_checks = 0;
        seed = 32'h00014A27;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        chk("reset", 80'h0, {loc_q, bu, oe, dz, quotient_q});
        ex(0, 0, 3'h3, 3'h3, 6'h00, 80'h3FFF_8000000000000000, FPAT_LOC_FPREG);
        ex(0, 0, 3'h1, 3'h2, 6'h15, 80'hFFFF_8000000000000000, FPAT_LOC_FPREG);
        ex(0, 0, 3'h1, 3'h2, 6'h00, 80'h8000_0000000000000000, FPAT_LOC_FPREG);
        foreach (hv[i])
            ex(1, 0, 3'h4, 3'h5, 6'h00, hv[i], FPAT_LOC_FPREG);
        foreach (eas[i])
            ex(0, 1, 3'h2, 3'h0, eas[i], 80'h3FFE_C000000000000000, locs[i]);
        foreach (fmts[i])
            ex(1, 1, fmts[i], 3'h1, 6'h3C, 80'h3FFF_8000000000000000, FPAT_LOC_IMM);
        ex(1, 1, 3'h6, 3'h7, 6'h03, 80'h3FFF_8000000000000000, FPAT_LOC_DREG);
        run(16'hF208, 16'h480C, 96'h0, 2'b01);
        run(16'hF200, 16'h480C, 96'h0, 2'b01);
        run(16'hF200, 16'h000E, 96'h0, 2'b01);
        run(16'hF400, 16'h000C, 96'h0, 2'b00);
        repeat (8)
        begin
            seed = lfsr(seed);
            ex(seed[0], 0, seed[3:1], seed[6:4], 6'h00, {seed[7], 11'h3FF, seed[11:8], 1'b1, seed[31:12],
                43'h0}, FPAT_LOC_FPREG);
        end
        end_of_test();
    end
endmodule : fpat_decode_tb

//--- fpat_host.sv
// ==========================================
// Main processor issuing instruction requests
module fpat_host
(
    // Clock.
    input wire logic clock,
    // Request to the coprocessor.
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [15:0] cmd_word0,
    output logic [15:0] cmd_word1,
    output logic [95:0] cmd_operand
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle request lines at time zero.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_word0 = 16'h0000;
        cmd_word1 = 16'h0000;
        cmd_operand = 96'h0;
    end
    // Holds one request until the edge that takes it, then scrambles the operand.
    task automatic issue(input logic [15:0] w0, input logic [15:0] w1, input logic [95:0] op);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_word0 = w1[14] ? w0 : {w0[15:6], 6'h00};
        cmd_word1 = w1;
        cmd_operand = op;
        while (cmd_ready !== 1'b1)
            @(negedge clock);
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_operand = ~op;
    endtask : issue
endmodule : fpat_host

//--- fpat_params.svh
`ifndef FPAT_PARAMS_SVH
`define FPAT_PARAMS_SVH

// ==========================================================================
// Instruction word fields
// ==========================================================================
`define FPAT_W0_LINE_HI 15
`define FPAT_W0_LINE_LO 12
`define FPAT_W0_LINE_VAL 4'hF
`define FPAT_W0_ID_HI 11
`define FPAT_W0_ID_LO 9
`define FPAT_W0_TYPE_HI 8
`define FPAT_W0_TYPE_LO 6
`define FPAT_W0_TYPE_VAL 3'h0
`define FPAT_W0_MODE_HI 5
`define FPAT_W0_MODE_LO 3
`define FPAT_W0_REG_HI 2
`define FPAT_W0_REG_LO 0
`define FPAT_W1_ZERO_HI 15
`define FPAT_W1_RM 14
`define FPAT_W1_ZERO_LO 13
`define FPAT_W1_SRC_HI 12
`define FPAT_W1_SRC_LO 10
`define FPAT_W1_DST_HI 9
`define FPAT_W1_DST_LO 7
`define FPAT_W1_OPM_HI 6
`define FPAT_W1_OPM_LO 0

// ==========================================================================
// Operation-mode codes
// ==========================================================================
`define FPAT_OPM_ATAN 7'h0C
`define FPAT_OPM_ATANH 7'h0D

// ==========================================================================
// Effective-address mode and register codes
// ==========================================================================
`define FPAT_EA_DREG 3'h0
`define FPAT_EA_AREG 3'h1
`define FPAT_EA_IND 3'h2
`define FPAT_EA_POSTINC 3'h3
`define FPAT_EA_PREDEC 3'h4
`define FPAT_EA_DISP 3'h5
`define FPAT_EA_INDEX 3'h6
`define FPAT_EA_EXT 3'h7
`define FPAT_EXT_ABSW 3'h0
`define FPAT_EXT_ABSL 3'h1
`define FPAT_EXT_PCDISP 3'h2
`define FPAT_EXT_PCIDX 3'h3
`define FPAT_EXT_IMM 3'h4

// ==========================================================================
// Extended-precision constants
// ==========================================================================
`define FPAT_BIAS 15'h3FFF
`define FPAT_EXP_MAX 15'h7FFF
`define FPAT_EXP_HUGE 15'h403F
`define FPAT_MANT_ONE 64'h8000000000000000
`define FPAT_HALF_PI_EXP 15'h3FFF
`define FPAT_HALF_PI_MANT 64'hC90FDAA22168C235
`define FPAT_QNAN_MANT 64'hFFFFFFFFFFFFFFFF
`define FPAT_QUIET_BIT 62
`define FPAT_SGL_BIAS 15'h007F
`define FPAT_DBL_BIAS 15'h03FF
`define FPAT_INT_EXP 15'h401E

// ==========================================================================
// Reset values
// ==========================================================================
`define FPAT_FLAGS_RST 8'h00
`define FPAT_QUOT_RST 8'h00
`define FPAT_FPR_RST 80'h0

`endif

//--- fpat_pkg.sv
package fpat_pkg;

    // Source format held in the source specifier when the operand is in memory.
    typedef enum logic [2:0] {
        FPAT_FMT_LONG = 3'h0,
        FPAT_FMT_SINGLE = 3'h1,
        FPAT_FMT_EXT = 3'h2,
        FPAT_FMT_PACKED = 3'h3,
        FPAT_FMT_WORD = 3'h4,
        FPAT_FMT_DOUBLE = 3'h5,
        FPAT_FMT_BYTE = 3'h6,
        FPAT_FMT_BAD = 3'h7
    } fpat_fmt_t;

    // Decoded operand location reported to the main processor.
    typedef enum logic [3:0] {
        FPAT_LOC_FPREG = 4'h0,
        FPAT_LOC_DREG = 4'h1,
        FPAT_LOC_IND = 4'h2,
        FPAT_LOC_POSTINC = 4'h3,
        FPAT_LOC_PREDEC = 4'h4,
        FPAT_LOC_DISP = 4'h5,
        FPAT_LOC_INDEX = 4'h6,
        FPAT_LOC_ABSW = 4'h7,
        FPAT_LOC_ABSL = 4'h8,
        FPAT_LOC_IMM = 4'h9,
        FPAT_LOC_PCDISP = 4'hA,
        FPAT_LOC_PCIDX = 4'hB,
        FPAT_LOC_ILLEGAL = 4'hF
    } fpat_loc_t;

    // Sequencer states, Gray coded along idle to execute and back.
    typedef enum logic [1:0] {
        FPAT_S_IDLE = 2'b00,
        FPAT_S_EXEC = 2'b01
    } fpat_state_t;

endpackage : fpat_pkg
